// *** vector_pkg.sv ***
// package: vector slots, placement constants and request carrier
package vector_pkg;
   localparam int unsigned NUM_SOURCES = 26;
   localparam int unsigned ADDR_W = 14;
   localparam logic [13:0] RESET_VECTOR_ADDR = 14'h0000;
   localparam logic [13:0] TABLE_BASE_ADDR = 14'h0002;
   localparam logic [13:0] VECTOR_STRIDE = 14'h0002;
   localparam logic [13:0] BOOT_RESET_ADDR_DEFAULT = 14'h1c00;
   localparam logic FUSE_PROGRAMMED = 1'b0;
   localparam logic FUSE_UNPROGRAMMED = 1'b1;
   localparam logic [4:0] SLOT_EXT0 = 5'h00;
   localparam logic [4:0] SLOT_EXT1 = 5'h01;
   localparam logic [4:0] SLOT_PC0 = 5'h02;
   localparam logic [4:0] SLOT_PC1 = 5'h03;
   localparam logic [4:0] SLOT_PC2 = 5'h04;
   localparam logic [4:0] SLOT_WATCHDOG = 5'h05;
   localparam logic [4:0] SLOT_TC2_A = 5'h06;
   localparam logic [4:0] SLOT_TC2_B = 5'h07;
   localparam logic [4:0] SLOT_TC2_WRAP = 5'h08;
   localparam logic [4:0] SLOT_TC1_CAP = 5'h09;
   localparam logic [4:0] SLOT_TC1_A = 5'h0a;
   localparam logic [4:0] SLOT_TC1_B = 5'h0b;
   localparam logic [4:0] SLOT_TC1_WRAP = 5'h0c;
   localparam logic [4:0] SLOT_TC0_A = 5'h0d;
   localparam logic [4:0] SLOT_TC0_B = 5'h0e;
   localparam logic [4:0] SLOT_TC0_WRAP = 5'h0f;
   localparam logic [4:0] SLOT_SPI = 5'h10;
   localparam logic [4:0] SLOT_UART_RX = 5'h11;
   localparam logic [4:0] SLOT_UART_EMPTY = 5'h12;
   localparam logic [4:0] SLOT_UART_TX = 5'h13;
   localparam logic [4:0] SLOT_CONV = 5'h14;
   localparam logic [4:0] SLOT_NV = 5'h15;
   localparam logic [4:0] SLOT_COMP = 5'h16;
   localparam logic [4:0] SLOT_TWO_WIRE = 5'h17;
   localparam logic [4:0] SLOT_STORE = 5'h18;
   localparam logic [4:0] SLOT_NONE = 5'h1f;

   typedef enum logic [1:0] {
      ST_RESET = 2'b00,
      ST_IDLE = 2'b01,
      ST_HOLD = 2'b10
   } locator_state_t;

   typedef struct packed {
      logic ext_request_zero;
      logic ext_request_one;
      logic pin_change_group_zero;
      logic pin_change_group_one;
      logic pin_change_group_two;
      logic watchdog_timeout_source;
      logic tc2_match_a;
      logic tc2_match_b;
      logic tc2_wrap;
      logic tc1_capture;
      logic tc1_match_a;
      logic tc1_match_b;
      logic tc1_wrap;
      logic tc0_match_a;
      logic tc0_match_b;
      logic tc0_wrap;
      logic serial_periph_xfer_done;
      logic uart_rx_done;
      logic uart_tx_buffer_empty;
      logic uart_tx_done;
      logic conversion_done;
      logic nv_data_ready;
      logic comparator_event;
      logic two_wire_event;
      logic program_store_ready;
   } irq_requests_t;

   typedef struct packed {
      logic valid;
      logic [4:0] slot;
      logic [13:0] addr;
   } vector_out_t;
endpackage

// *** vector_priority.sv ***
// lowest-slot-first pick among pending requests
`timescale 1ns/1ps
module vector_priority
   import vector_pkg::*;
#(
   parameter int unsigned N = NUM_SOURCES
) (
   // clocking
   input wire logic clock,
   input wire logic reset_n,
   input wire logic clock_en,
   // requests
   input wire logic [N-1:0] pending,
   // selection
   output logic found,
   output logic [4:0] slot
);
   if (N < 1 || N > 31) begin : g_bad_n
      $error("vector_priority: N out of range");
   end

   typedef struct packed {
      logic found;
      logic [4:0] slot;
   } pick_t;

   pick_t s_q, s_d;

   function automatic logic [4:0] lowest(input logic [N-1:0] v);
      logic [4:0] r;
      r = SLOT_NONE;
      for (int i = N - 1; i >= 0; i--) begin
         if (v[i]) begin
            r = 5'(i);
         end
      end
      return r;
   endfunction

   always_comb begin
      s_d = s_q;
      s_d.found = |pending;
      s_d.slot = lowest(pending);
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         s_q <= '{found: 1'b0, slot: SLOT_NONE};
      end else if (clock_en) begin
         s_q <= s_d;
      end
   end

   assign found = s_q.found;
   assign slot = s_q.slot;
endmodule // vector_priority

// *** reset_irq_vector_locator.sv ***
// reset and interrupt vector address locator
// Overview of operation
// - every reset cause uses address 0x0000 when the fuse is unprogrammed
// - external requests at 0x0002 then 0x0004
// - pin-change 0x0006-0x000A, watchdog 0x000C
// - timer two: 0x000E, 0x0010, 0x0012
// - timer one: 0x0014 through 0x001A
// - timer zero: 0x001C, 0x001E, 0x0020
// - serial peripheral done at 0x0022
// - uart: 0x0024, 0x0026, 0x0028
// - remaining sources 0x002A through 0x0032
// - programmed fuse sends reset to boot
// - select bit adds boot start to vectors
// - placement table for fuse and select
// - fuse one unprogrammed, zero programmed
`timescale 1ns/1ps
module reset_irq_vector_locator
   import vector_pkg::*;
#(
   parameter logic [13:0] BOOT_RESET_ADDR = BOOT_RESET_ADDR_DEFAULT
) (
   // clocking
   input wire logic clock,
   input wire logic reset_n,
   input wire logic clock_en,
   // configuration
   input wire logic boot_reset_select_fuse,
   input wire logic vector_table_select_bit,
   // requests
   input wire irq_requests_t requests,
   // core handshake
   input wire logic vector_accept,
   // fetch target
   output logic reset_fetch_valid,
   output logic irq_valid,
   output logic [4:0] irq_slot,
   output logic [13:0] fetch_addr
);
   if (BOOT_RESET_ADDR[0] != 1'b0) begin : g_bad_boot
      $error("boot reset address must be even");
   end

   typedef struct packed {
      locator_state_t state;
      logic reset_fetch;
      logic irq_valid;
      logic [4:0] slot;
      logic [13:0] addr;
   } locator_t;

   locator_t s_q, s_d;
   logic [NUM_SOURCES-1:0] pend_vec;
   logic pick_found;
   logic [4:0] pick_slot;

   // slot 0 is the first struct field, highest bit
   for (genvar g = 0; g < NUM_SOURCES - 1; g++) begin : g_order
      assign pend_vec[g] = requests[NUM_SOURCES - 2 - g];
   end
   assign pend_vec[NUM_SOURCES-1] = 1'b0;

   vector_priority #(
      .N(NUM_SOURCES)
   ) u_pick (
      .clock(clock),
      .reset_n(reset_n),
      .clock_en(clock_en),
      .pending(pend_vec),
      .found(pick_found),
      .slot(pick_slot)
   );

   function automatic logic [13:0] reset_target(input logic fuse);
      if (fuse == FUSE_PROGRAMMED) begin
         return BOOT_RESET_ADDR;
      end else begin
         return RESET_VECTOR_ADDR;
      end
   endfunction

   // slot k sits at base + 2k: 0x0002..0x0032
   function automatic logic [13:0] vector_addr(input logic sel, input logic [4:0] slot);
      logic [13:0] nominal;
      nominal = TABLE_BASE_ADDR + 14'(slot) * VECTOR_STRIDE;
      if (sel) begin
         return 14'(nominal + BOOT_RESET_ADDR);
      end else begin
         return nominal;
      end
   endfunction

   always_comb begin
      s_d = s_q;
      case (s_q.state)
         ST_RESET: begin
            s_d.reset_fetch = 1'b1;
            s_d.irq_valid = 1'b0;
            s_d.slot = SLOT_NONE;
            s_d.addr = reset_target(boot_reset_select_fuse);
            if (vector_accept) begin
               s_d.reset_fetch = 1'b0;
               s_d.state = ST_IDLE;
            end
         end
         ST_IDLE: begin
            s_d.reset_fetch = 1'b0;
            if (pick_found) begin
               s_d.irq_valid = 1'b1;
               s_d.slot = pick_slot;
               s_d.addr = vector_addr(vector_table_select_bit, pick_slot);
               s_d.state = ST_HOLD;
            end
         end
         ST_HOLD: begin
            if (vector_accept) begin
               s_d.irq_valid = 1'b0;
               s_d.state = ST_IDLE;
            end
         end
         default: begin
            s_d.state = ST_RESET;
         end
      endcase
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         s_q <= '{state: ST_RESET, reset_fetch: 1'b0, irq_valid: 1'b0, slot: SLOT_NONE, addr: RESET_VECTOR_ADDR};
      end else if (clock_en) begin
         s_q <= s_d;
      end
   end

   assign reset_fetch_valid = s_q.reset_fetch;
   assign irq_valid = s_q.irq_valid;
   assign irq_slot = s_q.slot;
   assign fetch_addr = s_q.addr;

   AST_RESET_ADDR: assert property (@(posedge clock) disable iff (!reset_n)
      (reset_fetch_valid && $past(clock_en) && $stable(boot_reset_select_fuse))
         |-> fetch_addr == ((boot_reset_select_fuse == FUSE_PROGRAMMED) ? BOOT_RESET_ADDR : RESET_VECTOR_ADDR))
      else $error("reset target wrong");
   AST_FUSE_ONE: assert property (@(posedge clock) disable iff (!reset_n)
      (reset_fetch_valid && $past(boot_reset_select_fuse) && $past(clock_en)) |-> fetch_addr == 14'h0000)
      else $error("unprogrammed fuse must reset to zero");
   AST_FIRST_EXT: assert property (@(posedge clock) disable iff (!reset_n)
      (irq_valid && irq_slot == SLOT_EXT0 && $rose(irq_valid) && !$past(vector_table_select_bit))
         |-> fetch_addr == 14'h0002)
      else $error("first external vector wrong");
   AST_WATCHDOG_ADDR: assert property (@(posedge clock) disable iff (!reset_n)
      ($rose(irq_valid) && irq_slot == SLOT_WATCHDOG && !$past(vector_table_select_bit)) |-> fetch_addr == 14'h000c)
      else $error("watchdog vector wrong");
   AST_TC1_WRAP: assert property (@(posedge clock) disable iff (!reset_n)
      ($rose(irq_valid) && irq_slot == SLOT_TC1_WRAP && !$past(vector_table_select_bit)) |-> fetch_addr == 14'h001a)
      else $error("timer one wrap vector wrong");
   AST_STORE: assert property (@(posedge clock) disable iff (!reset_n)
      ($rose(irq_valid) && irq_slot == SLOT_STORE && !$past(vector_table_select_bit)) |-> fetch_addr == 14'h0032)
      else $error("store ready vector wrong");
   AST_RELOCATE: assert property (@(posedge clock) disable iff (!reset_n)
      ($rose(irq_valid) && $past(vector_table_select_bit))
         |-> fetch_addr == 14'(BOOT_RESET_ADDR + TABLE_BASE_ADDR + 14'(irq_slot) * VECTOR_STRIDE))
      else $error("relocated vector wrong");
   AST_HOLD: assert property (@(posedge clock) disable iff (!reset_n)
      (irq_valid && !vector_accept && clock_en) |=> (irq_valid && $stable(fetch_addr) && $stable(irq_slot)))
      else $error("vector changed before accept");
   AST_LOWEST: assert property (@(posedge clock) disable iff (!reset_n)
      ($rose(irq_valid) && $past(pick_found)) |-> irq_slot == $past(pick_slot))
      else $error("priority pick not taken");
   AST_EXT_ONE: assert property (@(posedge clock) disable iff (!reset_n)
      ($rose(irq_valid) && irq_slot == SLOT_EXT1 && !$past(vector_table_select_bit)) |-> fetch_addr == 14'h0004)
      else $error("second external vector wrong");
   AST_PC_ZERO: assert property (@(posedge clock) disable iff (!reset_n)
      ($rose(irq_valid) && irq_slot == SLOT_PC0 && !$past(vector_table_select_bit)) |-> fetch_addr == 14'h0006)
      else $error("first pin-change vector wrong");
   AST_PC_TWO: assert property (@(posedge clock) disable iff (!reset_n)
      ($rose(irq_valid) && irq_slot == SLOT_PC2 && !$past(vector_table_select_bit)) |-> fetch_addr == 14'h000a)
      else $error("third pin-change vector wrong");
   AST_TC2_A: assert property (@(posedge clock) disable iff (!reset_n)
      ($rose(irq_valid) && irq_slot == SLOT_TC2_A && !$past(vector_table_select_bit)) |-> fetch_addr == 14'h000e)
      else $error("timer two match a vector wrong");
   AST_TC2_WRAP: assert property (@(posedge clock) disable iff (!reset_n)
      ($rose(irq_valid) && irq_slot == SLOT_TC2_WRAP && !$past(vector_table_select_bit)) |-> fetch_addr == 14'h0012)
      else $error("timer two wrap vector wrong");
   AST_TC1_CAP: assert property (@(posedge clock) disable iff (!reset_n)
      ($rose(irq_valid) && irq_slot == SLOT_TC1_CAP && !$past(vector_table_select_bit)) |-> fetch_addr == 14'h0014)
      else $error("timer one capture vector wrong");
   AST_TC0_A: assert property (@(posedge clock) disable iff (!reset_n)
      ($rose(irq_valid) && irq_slot == SLOT_TC0_A && !$past(vector_table_select_bit)) |-> fetch_addr == 14'h001c)
      else $error("timer zero match a vector wrong");
   AST_TC0_WRAP: assert property (@(posedge clock) disable iff (!reset_n)
      ($rose(irq_valid) && irq_slot == SLOT_TC0_WRAP && !$past(vector_table_select_bit)) |-> fetch_addr == 14'h0020)
      else $error("timer zero wrap vector wrong");
   AST_XFER_DONE: assert property (@(posedge clock) disable iff (!reset_n)
      ($rose(irq_valid) && irq_slot == SLOT_SPI && !$past(vector_table_select_bit)) |-> fetch_addr == 14'h0022)
      else $error("serial peripheral vector wrong");
   AST_UART_RX: assert property (@(posedge clock) disable iff (!reset_n)
      ($rose(irq_valid) && irq_slot == SLOT_UART_RX && !$past(vector_table_select_bit)) |-> fetch_addr == 14'h0024)
      else $error("uart receive vector wrong");
   AST_UART_EMPTY: assert property (@(posedge clock) disable iff (!reset_n)
      ($rose(irq_valid) && irq_slot == SLOT_UART_EMPTY && !$past(vector_table_select_bit))
         |-> fetch_addr == 14'h0026)
      else $error("uart buffer empty vector wrong");
   AST_UART_TX: assert property (@(posedge clock) disable iff (!reset_n)
      ($rose(irq_valid) && irq_slot == SLOT_UART_TX && !$past(vector_table_select_bit)) |-> fetch_addr == 14'h0028)
      else $error("uart transmit vector wrong");
   AST_CONV: assert property (@(posedge clock) disable iff (!reset_n)
      ($rose(irq_valid) && irq_slot == SLOT_CONV && !$past(vector_table_select_bit)) |-> fetch_addr == 14'h002a)
      else $error("conversion vector wrong");
   AST_NV: assert property (@(posedge clock) disable iff (!reset_n)
      ($rose(irq_valid) && irq_slot == SLOT_NV && !$past(vector_table_select_bit)) |-> fetch_addr == 14'h002c)
      else $error("nonvolatile ready vector wrong");
   AST_COMP: assert property (@(posedge clock) disable iff (!reset_n)
      ($rose(irq_valid) && irq_slot == SLOT_COMP && !$past(vector_table_select_bit)) |-> fetch_addr == 14'h002e)
      else $error("comparator vector wrong");
   AST_FUSE_ZERO: assert property (@(posedge clock) disable iff (!reset_n)
      (reset_fetch_valid && !$past(boot_reset_select_fuse) && $past(clock_en)) |-> fetch_addr == BOOT_RESET_ADDR)
      else $error("programmed fuse must reset to boot");
   AST_REFUSE: assert property (@(posedge clock) disable iff (!reset_n)
      reset_fetch_valid |-> !irq_valid)
      else $error("interrupt presented before reset fetch");
   AST_SLOT_RANGE: assert property (@(posedge clock) disable iff (!reset_n)
      irq_valid |-> irq_slot <= SLOT_STORE)
      else $error("presented slot out of range");
endmodule // reset_irq_vector_locator

// *** core_fetch_model.sv ***
// core-side model: takes presented reset and interrupt targets
`timescale 1ns/1ps
module core_fetch_model (
   // clocking
   input wire logic clock,
   input wire logic reset_n,
   input wire logic clock_en,
   // presented target
   input wire logic reset_fetch_valid,
   input wire logic irq_valid,
   input wire logic [1:0] delay,
   // handshake
   output logic vector_accept
);
   logic [1:0] wait_q;
   logic done_q;
   // accept held until an enabled edge takes it, then idle until valid drops
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         vector_accept <= 1'b0;
         wait_q <= 2'h0;
         done_q <= 1'b0;
      end else if (!(reset_fetch_valid || irq_valid)) begin
         vector_accept <= 1'b0;
         wait_q <= 2'h0;
         done_q <= 1'b0;
      end else if (vector_accept && clock_en) begin
         vector_accept <= 1'b0;
         done_q <= 1'b1;
      end else if (!done_q && wait_q == delay) begin
         vector_accept <= 1'b1;
      end else if (!done_q) begin
         wait_q <= wait_q + 2'h1;
      end
   end
endmodule // core_fetch_model

// *** reset_irq_vector_locator_test.sv ***
// self-checking bench for the vector locator
`timescale 1ns/1ps
`define CHK(what, exp, got) begin n_compared++; if ((exp) !== (got)) begin err_count++; \
   $display("mismatch %s expected %h seen %h", what, exp, got); end end
module reset_irq_vector_locator_test;
   import vector_pkg::*;
   localparam logic [13:0] BOOT = 14'h1c00;
   logic clock = 1'b0;
   logic reset_n = 1'b0;
   logic clock_en = 1'b1;
   logic fuse = 1'b1;
   logic sel = 1'b0;
   irq_requests_t requests = '0;
   logic [1:0] delay = 2'h0;
   logic vector_accept;
   logic reset_fetch_valid;
   logic irq_valid;
   logic [4:0] irq_slot;
   logic [13:0] fetch_addr;
   int err_count = 0;
   int n_compared = 0;
   logic [13:0] exp_tbl [25] = '{14'h0002, 14'h0004, 14'h0006, 14'h0008, 14'h000a, 14'h000c, 14'h000e,
      14'h0010, 14'h0012, 14'h0014, 14'h0016, 14'h0018, 14'h001a, 14'h001c, 14'h001e, 14'h0020,
      14'h0022, 14'h0024, 14'h0026, 14'h0028, 14'h002a, 14'h002c, 14'h002e, 14'h0030, 14'h0032};

   always #20 clock = ~clock;

   reset_irq_vector_locator #(.BOOT_RESET_ADDR(BOOT)) i_dut (.clock(clock), .reset_n(reset_n),
      .clock_en(clock_en), .boot_reset_select_fuse(fuse), .vector_table_select_bit(sel),
      .requests(requests), .vector_accept(vector_accept), .reset_fetch_valid(reset_fetch_valid),
      .irq_valid(irq_valid), .irq_slot(irq_slot), .fetch_addr(fetch_addr));
   core_fetch_model i_core (.clock(clock), .reset_n(reset_n), .clock_en(clock_en),
      .reset_fetch_valid(reset_fetch_valid), .irq_valid(irq_valid), .delay(delay),
      .vector_accept(vector_accept));

   task automatic test_done;
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // bounded wait on irq_valid (want_irq) or reset_fetch_valid
   task automatic wait_for(input logic want_irq, input logic lvl);
      int n;
      n = 0;
      while (((want_irq ? irq_valid : reset_fetch_valid) !== lvl) && n < 20) begin
         @(negedge clock);
         n++;
      end
      if ((want_irq ? irq_valid : reset_fetch_valid) !== lvl) begin
         err_count++;
         $display("mismatch wait expected %h seen %h", lvl, ~lvl);
         test_done();
      end
   endtask

   task automatic do_reset(input logic f);
      @(negedge clock);
      reset_n = 1'b0;
      fuse = f;
      repeat (10) @(negedge clock);
      `CHK("slot in reset", 5'h1f, irq_slot)
      `CHK("addr in reset", 14'h0000, fetch_addr)
      `CHK("valid in reset", 1'b0, reset_fetch_valid)
      reset_n = 1'b1;
      wait_for(1'b0, 1'b1);
      `CHK("irq in reset fetch", 1'b0, irq_valid)
      `CHK("reset target", f ? 14'h0000 : BOOT, fetch_addr)
      wait_for(1'b0, 1'b0);
   endtask

   task automatic take(input int s, input logic [13:0] exp);
      wait_for(1'b1, 1'b1);
      `CHK("slot", s[4:0], irq_slot)
      `CHK("vector addr", exp, fetch_addr)
   endtask

   initial begin
      #2000000;
      err_count++;
      test_done();
   end

   initial begin
      // fuse and select combinations, request held through reset
      for (int c = 0; c < 4; c++) begin
         requests = '0;
         requests.ext_request_zero = 1'b1;
         sel = c[0];
         do_reset(c[1]);
         take(0, 14'h0002 + (sel ? BOOT : 14'h0000));
         requests = '0;
         wait_for(1'b1, 1'b0);
         $display("placement case %0d done", c);
      end
      // one row per source slot
      for (int i = 0; i < 25; i++) begin
         @(negedge clock);
         sel = i[0];
         delay = i[1:0];
         requests = irq_requests_t'(25'h1 << (24 - i));
         take(i, exp_tbl[i] + (sel ? BOOT : 14'h0000));
         requests = '0;
         wait_for(1'b1, 1'b0);
         $display("row %0d done", i);
      end
      // two pending: lower slot first, then the other re-presented
      @(negedge clock);
      sel = 1'b0;
      delay = 2'h3;
      requests.pin_change_group_one = 1'b1;
      requests.tc2_match_b = 1'b1;
      take(3, 14'h0008);
      requests.pin_change_group_one = 1'b0;
      wait_for(1'b1, 1'b0);
      take(7, 14'h0010);
      // frozen clock enable holds the presented vector
      clock_en = 1'b0;
      requests = '0;
      repeat (6) @(negedge clock);
      `CHK("frozen valid", 1'b1, irq_valid)
      `CHK("frozen slot", 5'h07, irq_slot)
      clock_en = 1'b1;
      wait_for(1'b1, 1'b0);
      repeat (4) @(negedge clock);
      `CHK("idle without request", 1'b0, irq_valid)
      $display("priority and freeze done");
      test_done();
   end
endmodule // reset_irq_vector_locator_test
